// File: design/tbb_pkg.sv
// Constants, field layouts and carrier types for the registered
// two-way bus transceiver. Assumes a single 250 MHz core clock.
//
// Notes on behaviour
// - Two independent 8-bit halves, alone or joined as one 16-bit unit.
// - Rising capture clock edge loads A into A-side, B into B-side register.
// - Capture happens on every edge, whatever enable and direction say.
// - Enable inactive: drive neither bus, still capture, else hold storage.
// - While one bus is driven, the other bus can be stored anywhere.
// - Enable active: direction low drives A from B, high drives B.
// - Direction low, B-to-A select low: live B value goes onto A.
// - Direction low, B-to-A select high: stored B register drives A.
// - Direction high, A-to-B select low: live A value goes onto B.
// - Direction high, A-to-B select high: stored A register drives B.
// - Never drive a half's A lines and B lines at the same moment.
// - Switching between live and stored data gives no glitch.
package tbb_pkg;

  // ==========================================================
  // Geometry
  localparam int unsigned TBB_HALF_W    = 8;
  localparam int unsigned TBB_HALVES    = 2;
  localparam int unsigned TBB_ADDR_W    = 5;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [4:0] TBB_OFS_CTRL    = 5'h00;
  localparam logic [4:0] TBB_OFS_STORE_A = 5'h04;
  localparam logic [4:0] TBB_OFS_STORE_B = 5'h08;
  localparam logic [4:0] TBB_OFS_DRIVE   = 5'h0C;
  localparam logic [4:0] TBB_OFS_LINES   = 5'h10;

  // ==========================================================
  // Control register fields; half n sits at bit n*TBB_CTRL_STRIDE
  localparam int unsigned TBB_CTRL_STRIDE = 8;
  localparam int unsigned TBB_BIT_SEL_BA  = 0;
  localparam int unsigned TBB_BIT_SEL_AB  = 1;
  localparam int unsigned TBB_BIT_DIR     = 2;
  localparam int unsigned TBB_BIT_OE_N    = 3;
  localparam int unsigned TBB_BIT_GANG    = 16;
  localparam logic [31:0] TBB_CTRL_RESET  = 32'h0000_0808;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] TBB_RESP_OKAY   = 2'b00;
  localparam logic [1:0] TBB_RESP_SLVERR = 2'b10;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic oe_n;
    logic dir;
    logic a_to_b_source_select;
    logic b_to_a_source_select;
  } tbb_ctrl_t;

  typedef struct packed {
    logic [TBB_HALF_W-1:0] data;
    logic [TBB_HALF_W-1:0] en;
  } tbb_drive_t;

endpackage : tbb_pkg

// File: design/tbb_half.sv
// One 8-bit transceiver half: two storage registers, source select
// and output control. Assumes inputs synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

module tbb_half
  import tbb_pkg::*;
#(
  parameter int unsigned WIDTH = TBB_HALF_W
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Control
  input  wire tbb_ctrl_t        ctrl,
  input  wire logic             a_to_b_capture_clock,
  input  wire logic             b_to_a_capture_clock,
  // Line inputs
  input  wire logic [WIDTH-1:0] a_side_lines_in,
  input  wire logic [WIDTH-1:0] b_side_lines_in,
  // Line drivers
  output tbb_drive_t            a_side_lines_drv,
  output tbb_drive_t            b_side_lines_drv,
  // Stored contents
  output logic      [WIDTH-1:0] a_store,
  output logic      [WIDTH-1:0] b_store
);

  // ==========================================================
  // Parameter check
  if (WIDTH != TBB_HALF_W) begin : g_bad_width
    $error("tbb_half: WIDTH must match the carrier width");
  end

  logic prev_ab_clk;
  logic prev_ba_clk;
  logic ab_edge;
  logic ba_edge;

  // ==========================================================
  // Capture edges
  // Previous samples reset high so a clock high at release is no edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_ab_clk <= 1'b1;
      prev_ba_clk <= 1'b1;
    end else begin
      prev_ab_clk <= a_to_b_capture_clock;
      prev_ba_clk <= b_to_a_capture_clock;
    end
  end

  assign ab_edge = a_to_b_capture_clock & ~prev_ab_clk;
  assign ba_edge = b_to_a_capture_clock & ~prev_ba_clk;

  // ==========================================================
  // Storage: no gating by enable or direction
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_store <= '0;
    end else if (ab_edge) begin
      a_store <= a_side_lines_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      b_store <= '0;
    end else if (ba_edge) begin
      b_store <= b_side_lines_in;
    end
  end

  // ==========================================================
  // Outputs
  // Data and enables both leave flip-flops, so a select change moves
  // the whole word at one edge and no mux decode glitch reaches a pin.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_side_lines_drv <= '0;
      b_side_lines_drv <= '0;
    end else begin
      a_side_lines_drv.data <= ctrl.b_to_a_source_select ? b_store
                                                         : b_side_lines_in;
      b_side_lines_drv.data <= ctrl.a_to_b_source_select ? a_store
                                                         : a_side_lines_in;
      // Both enables come from one decode in one edge: never both high
      a_side_lines_drv.en <= {WIDTH{~ctrl.oe_n & ~ctrl.dir}};
      b_side_lines_drv.en <= {WIDTH{~ctrl.oe_n &  ctrl.dir}};
    end
  end

endmodule // tbb_half

`default_nettype wire

// File: design/tbb_top.sv
// Registered two-way bus transceiver, two halves, with an AXI4-Lite
// control slave. Assumes all pins synchronous to core_clk; the pads
// outside resolve each line from its enable.
`timescale 1ns/10ps
`default_nettype none

module tbb_top
  import tbb_pkg::*;
#(
  parameter int unsigned HALVES = TBB_HALVES
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // AXI4-Lite write address
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [TBB_ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  // AXI4-Lite write response
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  output logic [1:0]                       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  input  wire logic [TBB_ADDR_W-1:0]       s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  // AXI4-Lite read data
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  // Capture clocks, one pair per half
  input  wire logic [HALVES-1:0]           a_to_b_capture_clock,
  input  wire logic [HALVES-1:0]           b_to_a_capture_clock,
  // A side lines
  input  wire logic [HALVES*TBB_HALF_W-1:0] a_side_lines_in,
  output logic      [HALVES*TBB_HALF_W-1:0] a_side_lines_out,
  output logic      [HALVES*TBB_HALF_W-1:0] a_side_lines_oe,
  // B side lines
  input  wire logic [HALVES*TBB_HALF_W-1:0] b_side_lines_in,
  output logic      [HALVES*TBB_HALF_W-1:0] b_side_lines_out,
  output logic      [HALVES*TBB_HALF_W-1:0] b_side_lines_oe
);

  // ==========================================================
  // Parameter check
  // Register map packs both halves into one word per kind
  if (HALVES != TBB_HALVES) begin : g_bad_halves
    $error("tbb_top: HALVES must be 2");
  end

  localparam int unsigned W = TBB_HALF_W;

  logic [31:0]                  ctrl_reg;
  tbb_ctrl_t  [HALVES-1:0]      half_ctrl;
  logic [HALVES*W-1:0]          a_store_all;
  logic [HALVES*W-1:0]          b_store_all;
  tbb_drive_t [HALVES-1:0]      a_drv;
  tbb_drive_t [HALVES-1:0]      b_drv;

  logic                         aw_held;
  logic [TBB_ADDR_W-1:0]        aw_addr;
  logic                         w_held;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         do_write;
  logic                         wr_hit;
  logic                         rd_hit;
  logic [31:0]                  next_rdata;
  logic [31:0]                  next_ctrl;

  // ==========================================================
  // Per-half controls
  // Gang bit copies half 0 controls to every half: one 16-bit unit
  for (genvar h = 0; h < HALVES; h++) begin : g_ctrl
    localparam int unsigned SRC = h * TBB_CTRL_STRIDE;
    localparam int unsigned G0  = 0;
    always_comb begin
      if (ctrl_reg[TBB_BIT_GANG]) begin
        half_ctrl[h].oe_n = ctrl_reg[G0 + TBB_BIT_OE_N];
        half_ctrl[h].dir  = ctrl_reg[G0 + TBB_BIT_DIR];
        half_ctrl[h].a_to_b_source_select = ctrl_reg[G0 + TBB_BIT_SEL_AB];
        half_ctrl[h].b_to_a_source_select = ctrl_reg[G0 + TBB_BIT_SEL_BA];
      end else begin
        half_ctrl[h].oe_n = ctrl_reg[SRC + TBB_BIT_OE_N];
        half_ctrl[h].dir  = ctrl_reg[SRC + TBB_BIT_DIR];
        half_ctrl[h].a_to_b_source_select = ctrl_reg[SRC + TBB_BIT_SEL_AB];
        half_ctrl[h].b_to_a_source_select = ctrl_reg[SRC + TBB_BIT_SEL_BA];
      end
    end
  end

  // ==========================================================
  // Halves
  for (genvar h = 0; h < HALVES; h++) begin : g_half
    tbb_half #(
      .WIDTH (W)
    ) u_half (
      .core_clk             (core_clk),
      .rst                  (rst),
      .ctrl                 (half_ctrl[h]),
      .a_to_b_capture_clock (a_to_b_capture_clock[h]),
      .b_to_a_capture_clock (b_to_a_capture_clock[h]),
      .a_side_lines_in      (a_side_lines_in[h*W +: W]),
      .b_side_lines_in      (b_side_lines_in[h*W +: W]),
      .a_side_lines_drv     (a_drv[h]),
      .b_side_lines_drv     (b_drv[h]),
      .a_store              (a_store_all[h*W +: W]),
      .b_store              (b_store_all[h*W +: W])
    );

    assign a_side_lines_out[h*W +: W] = a_drv[h].data;
    assign a_side_lines_oe[h*W +: W]  = a_drv[h].en;
    assign b_side_lines_out[h*W +: W] = b_drv[h].data;
    assign b_side_lines_oe[h*W +: W]  = b_drv[h].en;
  end

  // ==========================================================
  // Write channel
  // Address and data are taken in either order; the answer waits
  // until both are held and the previous response has gone.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Only the control word is writable; the rest are read-only views
  assign wr_hit = (aw_addr == TBB_OFS_CTRL);

  always_comb begin
    next_ctrl = ctrl_reg;
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        next_ctrl[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= TBB_CTRL_RESET;
    end else if (do_write && wr_hit) begin
      ctrl_reg <= next_ctrl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TBB_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? TBB_RESP_OKAY : TBB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    next_rdata = '0;
    rd_hit     = 1'b1;
    case (s_axi_araddr)
      TBB_OFS_CTRL:    next_rdata = ctrl_reg;
      TBB_OFS_STORE_A: next_rdata[HALVES*W-1:0] = a_store_all;
      TBB_OFS_STORE_B: next_rdata[HALVES*W-1:0] = b_store_all;
      TBB_OFS_DRIVE: begin
        for (int h = 0; h < HALVES; h++) begin
          next_rdata[2*h]     = a_drv[h].en[0];
          next_rdata[2*h + 1] = b_drv[h].en[0];
        end
      end
      TBB_OFS_LINES: begin
        next_rdata[HALVES*W-1:0]       = a_side_lines_in;
        next_rdata[2*HALVES*W-1:HALVES*W] = b_side_lines_in;
      end
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= TBB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_hit ? TBB_RESP_OKAY : TBB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // tbb_top

`default_nettype wire

// File: tb/tbb_top_asserts.sv
// Checker for the transceiver top: shadow control word and store model.
// Assumes it is bound to tbb_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none

module tbb_top_asserts
  import tbb_pkg::*;
#(
  parameter int unsigned HALVES = TBB_HALVES
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Write path
  input  wire logic                          s_axi_awvalid,
  input  wire logic                          s_axi_awready,
  input  wire logic [TBB_ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                          s_axi_wvalid,
  input  wire logic                          s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_bvalid,
  // Capture clocks
  input  wire logic [HALVES-1:0]             a_to_b_capture_clock,
  input  wire logic [HALVES-1:0]             b_to_a_capture_clock,
  // Lines
  input  wire logic [HALVES*TBB_HALF_W-1:0]  a_side_lines_in,
  input  wire logic [HALVES*TBB_HALF_W-1:0]  a_side_lines_out,
  input  wire logic [HALVES*TBB_HALF_W-1:0]  a_side_lines_oe,
  input  wire logic [HALVES*TBB_HALF_W-1:0]  b_side_lines_in,
  input  wire logic [HALVES*TBB_HALF_W-1:0]  b_side_lines_out,
  input  wire logic [HALVES*TBB_HALF_W-1:0]  b_side_lines_oe
);
  localparam int unsigned HW = TBB_HALF_W;
  logic [TBB_ADDR_W-1:0]   aw_q;
  logic [31:0]             w_q;
  logic [3:0]              s_q;
  logic [31:0]             shd;
  logic                    bv_q;
  logic [HALVES-1:0]       ab_q;
  logic [HALVES-1:0]       ba_q;
  logic [HALVES*HW-1:0]    a_st;
  logic [HALVES*HW-1:0]    b_st;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Shadow control, applied when the write answer appears
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shd <= TBB_CTRL_RESET;
      bv_q <= 1'b0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        s_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && !bv_q && aw_q == TBB_OFS_CTRL) begin
        for (int i = 0; i < 4; i++) begin
          if (s_q[i]) shd[i*8 +: 8] <= w_q[i*8 +: 8];
        end
      end
    end
  end

  // ==========================================================
  // Store model; a clock already high at release is no edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ab_q <= '1;
      ba_q <= '1;
      a_st <= '0;
      b_st <= '0;
    end else begin
      ab_q <= a_to_b_capture_clock;
      ba_q <= b_to_a_capture_clock;
      for (int h = 0; h < HALVES; h++) begin
        if (a_to_b_capture_clock[h] && !ab_q[h])
          a_st[h*HW +: HW] <= a_side_lines_in[h*HW +: HW];
        if (b_to_a_capture_clock[h] && !ba_q[h])
          b_st[h*HW +: HW] <= b_side_lines_in[h*HW +: HW];
      end
    end
  end

  // ==========================================================
  // Per-half output checks
  for (genvar h = 0; h < HALVES; h++) begin : g_half
    localparam int unsigned L = h*HW;
    logic [3:0] c;
    logic       on_a;
    logic       on_b;
    assign c = (h > 0 && shd[TBB_BIT_GANG]) ? shd[3:0]
                                            : shd[h*TBB_CTRL_STRIDE +: 4];
    assign on_a = !c[TBB_BIT_OE_N] && !c[TBB_BIT_DIR];
    assign on_b = !c[TBB_BIT_OE_N] && c[TBB_BIT_DIR];

    property p_oe_a;
      a_side_lines_oe[L +: HW] == {HW{on_a}};
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("A enable wrong");
    property p_oe_b;
      b_side_lines_oe[L +: HW] == {HW{on_b}};
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("B enable wrong");
    property p_one;
      (a_side_lines_oe[L +: HW] & b_side_lines_oe[L +: HW]) == '0;
    endproperty
    a_one: assert property (p_one) else $error("Both buses driven");
    property p_live_a;
      on_a && !c[TBB_BIT_SEL_BA] |->
        a_side_lines_out[L +: HW] == $past(b_side_lines_in[L +: HW]);
    endproperty
    a_live_a: assert property (p_live_a) else $error("Live B to A");
    property p_st_a;
      on_a && c[TBB_BIT_SEL_BA] |->
        a_side_lines_out[L +: HW] == $past(b_st[L +: HW]);
    endproperty
    a_st_a: assert property (p_st_a) else $error("Stored B to A");
    property p_live_b;
      on_b && !c[TBB_BIT_SEL_AB] |->
        b_side_lines_out[L +: HW] == $past(a_side_lines_in[L +: HW]);
    endproperty
    a_live_b: assert property (p_live_b) else $error("Live A to B");
    property p_st_b;
      on_b && c[TBB_BIT_SEL_AB] |->
        b_side_lines_out[L +: HW] == $past(a_st[L +: HW]);
    endproperty
    a_st_b: assert property (p_st_b) else $error("Stored A to B");
    // Switch edge must already show the new source, with no dropped enable
    property p_glitch;
      on_a && $changed(c[TBB_BIT_SEL_BA]) |->
        (a_side_lines_oe[L +: HW] == '1 && a_side_lines_out[L +: HW] ==
           (c[TBB_BIT_SEL_BA] ? $past(b_st[L +: HW])
                              : $past(b_side_lines_in[L +: HW])))
        ##1 a_side_lines_oe[L +: HW] == '1;
    endproperty
    a_glitch: assert property (p_glitch) else $error("Drop on switch");
    property p_glitch_b;
      on_b && $changed(c[TBB_BIT_SEL_AB]) |->
        (b_side_lines_oe[L +: HW] == '1 && b_side_lines_out[L +: HW] ==
           (c[TBB_BIT_SEL_AB] ? $past(a_st[L +: HW])
                              : $past(a_side_lines_in[L +: HW])))
        ##1 b_side_lines_oe[L +: HW] == '1;
    endproperty
    a_glitch_b: assert property (p_glitch_b) else $error("B switch");
  end
endmodule // tbb_top_asserts

bind tbb_top tbb_top_asserts #(.HALVES(HALVES)) tbb_top_asserts_i (
  .core_clk(core_clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
  .a_to_b_capture_clock(a_to_b_capture_clock),
  .b_to_a_capture_clock(b_to_a_capture_clock),
  .a_side_lines_in(a_side_lines_in), .a_side_lines_out(a_side_lines_out),
  .a_side_lines_oe(a_side_lines_oe), .b_side_lines_in(b_side_lines_in),
  .b_side_lines_out(b_side_lines_out), .b_side_lines_oe(b_side_lines_oe)
);
`default_nettype wire

// File: tb/tbb_far_end.sv
// Far-side logic on both buses: resolves each line from the enables.
// Assumes the bench supplies the values the far logic wants to drive.
`timescale 1ns/10ps
`default_nettype none

module tbb_far_end
  import tbb_pkg::*;
#(
  parameter int unsigned W = TBB_HALVES*TBB_HALF_W
) (
  // Device drivers
  input  wire logic [W-1:0] a_side_lines_out,
  input  wire logic [W-1:0] a_side_lines_oe,
  input  wire logic [W-1:0] b_side_lines_out,
  input  wire logic [W-1:0] b_side_lines_oe,
  // Values the far logic offers
  input  wire logic [W-1:0] a_far,
  input  wire logic [W-1:0] b_far,
  // Resolved lines
  output logic      [W-1:0] a_side_lines_in,
  output logic      [W-1:0] b_side_lines_in
);
  // Far logic lets go of every line the device drives
  assign a_side_lines_in = (a_side_lines_oe & a_side_lines_out)
                         | (~a_side_lines_oe & a_far);
  assign b_side_lines_in = (b_side_lines_oe & b_side_lines_out)
                         | (~b_side_lines_oe & b_far);
endmodule // tbb_far_end
`default_nettype wire

// File: tb/tbb_top_tb_top.sv
// Testbench for the transceiver top: AXI4-Lite tasks and bus scenarios.
// Assumes the checker is bound in and the far end resolves the lines.
`timescale 1ns/10ps
`default_nettype none

module tbb_top_tb_top
  import tbb_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [4:0]  awa = '0, ara = '0;
  logic [31:0] wd = '0;
  logic [1:0]  ab_clk = '0, ba_clk = '0;
  logic [15:0] a_far = '0, b_far = '0;
  logic        awr, wr_rdy, bv, arr, rv;
  logic [1:0]  br, rr;
  logic [31:0] rd_d;
  logic [15:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  int          bad_count = 0;
  int          comparisons = 0;
  logic [3:0]  md [4] = '{4'h0, 4'h1, 4'h4, 4'h6};
  logic [7:0]  ev [4] = '{8'h3C, 8'h5A, 8'hC3, 8'hA5};

  tbb_top tbb_top_i (
    .core_clk(core_clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .s_axi_rdata(rd_d), .s_axi_rresp(rr),
    .a_to_b_capture_clock(ab_clk), .b_to_a_capture_clock(ba_clk),
    .a_side_lines_in(a_in), .a_side_lines_out(a_out), .a_side_lines_oe(a_oe),
    .b_side_lines_in(b_in), .b_side_lines_out(b_out), .b_side_lines_oe(b_oe));
  tbb_far_end tbb_far_end_i (
    .a_side_lines_out(a_out), .a_side_lines_oe(a_oe), .b_side_lines_out(b_out),
    .b_side_lines_oe(b_oe), .a_far(a_far), .b_far(b_far),
    .a_side_lines_in(a_in), .b_side_lines_in(b_in));

  initial forever #2 core_clk = ~core_clk;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] ad, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, b;
    logic [1:0] r;
    @(posedge core_clk);
    awv <= 1'b1; awa <= ad; wv <= 1'b1; wd <= d; bry <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = awv && awr; tw = wv && wr_rdy; b = bv; r = br;
      @(posedge core_clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!b);
    bry <= 1'b0;
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [4:0] ad, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ta, v;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge core_clk);
    arv <= 1'b1; ara <= ad; rry <= 1'b1;
    do begin
      @(negedge core_clk);
      ta = arv && arr; v = rv; d = rd_d; r = rr;
      @(posedge core_clk);
      if (ta) arv <= 1'b0;
    end while (!v);
    rry <= 1'b0;
    check(d, ed);
    check({30'h0, r}, {30'h0, er});
  endtask
  task automatic pulse(input logic [1:0] ab, input logic [1:0] ba);
    @(posedge core_clk);
    ab_clk <= ab; ba_clk <= ba;
    @(posedge core_clk);
    ab_clk <= 2'b00; ba_clk <= 2'b00;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(TBB_OFS_CTRL, TBB_CTRL_RESET, TBB_RESP_OKAY);
    rd(5'h14, 32'h0, TBB_RESP_SLVERR);
    wr(TBB_OFS_STORE_A, 32'h1, TBB_RESP_SLVERR);
    a_far <= 16'h96A5; b_far <= 16'h695A;
    pulse(2'b11, 2'b11);
    a_far <= 16'h0FC3; b_far <= 16'hF03C;
    rd(TBB_OFS_STORE_A, 32'h96A5, TBB_RESP_OKAY);
    rd(TBB_OFS_STORE_B, 32'h695A, TBB_RESP_OKAY);
    rd(TBB_OFS_DRIVE, 32'h0, TBB_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(TBB_OFS_CTRL, {28'h000_0080, md[i]}, TBB_RESP_OKAY);
      settle();
      check({a_oe, b_oe}, md[i][2] ? 32'h0000_00FF : 32'h00FF_0000);
      check({24'h0, md[i][2] ? b_out[7:0] : a_out[7:0]}, {24'h0, ev[i]});
      rd(TBB_OFS_DRIVE, md[i][2] ? 32'h2 : 32'h1, TBB_RESP_OKAY);
    end
    pulse(2'b01, 2'b00);
    settle();
    check({24'h0, b_out[7:0]}, 32'h0000_00C3);
    rd(TBB_OFS_STORE_A, 32'h96C3, TBB_RESP_OKAY);
    wr(TBB_OFS_CTRL, 32'h0001_0804, TBB_RESP_OKAY);
    settle();
    check({a_oe, b_oe}, 32'h0000_FFFF);
    check({16'h0, b_out}, 32'h0000_0FC3);
    // Halves apart: half 0 drives B live, half 1 drives A live
    wr(TBB_OFS_CTRL, 32'h0000_0004, TBB_RESP_OKAY);
    settle();
    check({a_oe, b_oe}, 32'hFF00_00FF);
    check({16'h0, a_out[15:8], b_out[7:0]}, 32'h0000_F0C3);
    rd(TBB_OFS_DRIVE, 32'h6, TBB_RESP_OKAY);
    results();
  end

  initial begin
    repeat (4000) @(posedge core_clk);
    bad_count++;
    results();
  end
endmodule // tbb_top_tb_top
`default_nettype wire
